//--- design/fmr_pkg.sv
package fmr_pkg;

   localparam int DATA_W = 8;
   localparam int MSB    = 7;
   localparam int LSB    = 0;

   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic       FLAG_RESET = 1'b0;

   // Operation codes presented by the decoder on opCode.
   localparam logic [3:0] OP_MOVE_TO_ACC = 4'h0;
   localparam logic [3:0] OP_MOVE_TO_MEM = 4'h1;
   localparam logic [3:0] OP_OR_TO_ACC   = 4'h2;
   localparam logic [3:0] OP_OR_TO_MEM   = 4'h3;
   localparam logic [3:0] OP_ROT_MEM     = 4'h4;
   localparam logic [3:0] OP_ROT_ACC     = 4'h5;
   localparam logic [3:0] OP_ROTC_MEM    = 4'h6;
   localparam logic [3:0] OP_ROTC_ACC    = 4'h7;

   typedef enum logic [2:0] {
      FMR_IDLE  = 3'b001,
      FMR_READ  = 3'b010,
      FMR_WRITE = 3'b100
   } fmr_state_t;

endpackage

//--- design/fmr_core.sv
// Function
// - Move-to-accumulator loads memory byte, flags kept.
// - Move-to-memory writes accumulator, flags kept.
// - OR to accumulator, zero flag only.
// - OR to memory, zero flag only.
// - Rotate memory left in place, no flags.
// - Rotate left into accumulator, memory kept.
// - Rotate memory left through carry, in place.
// - Rotate through carry into accumulator.
`timescale 1ns/10ps
module fmr_core
   import fmr_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        opStart,
   input  wire logic [3:0]  opCode,
   input  wire logic [7:0]  memAddrIn,
   input  wire logic [7:0]  memRdData,
   output logic             opBusy,
   output logic             opDone,
   output logic             memRdEn,
   output logic             memWrEn,
   output logic [7:0]       memAddr,
   output logic [7:0]       memWrData,
   output logic [7:0]       acc,
   output logic             zeroFlag,
   output logic             carryFlag
);

   // Read data must stand while memRdEn is high: the result is taken at
   // the edge that ends the strobe, which saves a wait state per access.
   function automatic logic [7:0] rotLeft(input logic [7:0] v,
                                          input logic       inBit);
      rotLeft = {v[MSB-1:LSB], inBit};
   endfunction

   fmr_state_t  state;
   fmr_state_t  next_state;
   logic [3:0]  op;
   logic [3:0]  next_op;
   logic [7:0]  next_acc;
   logic        next_zeroFlag;
   logic        next_carryFlag;
   logic        next_memRdEn;
   logic        next_memWrEn;
   logic [7:0]  next_memAddr;
   logic [7:0]  next_memWrData;
   logic        next_opDone;
   logic [7:0]  orVal;

   always_comb begin
      next_state     = state;
      next_op        = op;
      next_acc       = acc;
      next_zeroFlag  = zeroFlag;
      next_carryFlag = carryFlag;
      next_memRdEn   = 1'b0;
      next_memWrEn   = 1'b0;
      next_memAddr   = memAddr;
      next_memWrData = memWrData;
      next_opDone    = 1'b0;
      orVal          = acc | memRdData;
      case (state)
         FMR_IDLE: begin
            if (opStart) begin
               next_op      = opCode;
               next_memAddr = memAddrIn;
               if (opCode == OP_MOVE_TO_ACC || opCode == OP_MOVE_TO_MEM ||
                   opCode == OP_OR_TO_ACC || opCode == OP_OR_TO_MEM ||
                   opCode == OP_ROT_MEM || opCode == OP_ROT_ACC ||
                   opCode == OP_ROTC_MEM || opCode == OP_ROTC_ACC) begin
                  if (opCode == OP_MOVE_TO_MEM) begin
                     // No read needed; accumulator goes straight out.
                     next_memWrEn   = 1'b1;
                     next_memWrData = acc;
                     next_state     = FMR_WRITE;
                  end else begin
                     next_memRdEn = 1'b1;
                     next_state   = FMR_READ;
                  end
               end else begin
                  // Unknown codes complete at once with no effect.
                  next_opDone = 1'b1;
               end
            end
         end
         FMR_READ: begin
            next_state = FMR_IDLE;
            next_opDone = 1'b1;
            case (op)
               OP_MOVE_TO_ACC: begin
                  next_acc = memRdData;
               end
               OP_OR_TO_ACC: begin
                  next_acc      = orVal;
                  next_zeroFlag = (orVal == 8'h00);
               end
               OP_OR_TO_MEM: begin
                  next_memWrData = orVal;
                  next_zeroFlag  = (orVal == 8'h00);
                  next_memWrEn   = 1'b1;
                  next_opDone    = 1'b0;
                  next_state     = FMR_WRITE;
               end
               OP_ROT_MEM: begin
                  next_memWrData = rotLeft(memRdData,
                                           memRdData[MSB]);
                  next_memWrEn   = 1'b1;
                  next_opDone    = 1'b0;
                  next_state     = FMR_WRITE;
               end
               OP_ROT_ACC: begin
                  next_acc = rotLeft(memRdData, memRdData[MSB]);
               end
               OP_ROTC_MEM: begin
                  next_memWrData = rotLeft(memRdData, carryFlag);
                  next_carryFlag = memRdData[MSB];
                  next_memWrEn   = 1'b1;
                  next_opDone    = 1'b0;
                  next_state     = FMR_WRITE;
               end
               OP_ROTC_ACC: begin
                  next_acc       = rotLeft(memRdData, carryFlag);
                  next_carryFlag = memRdData[MSB];
               end
               default: begin
               end
            endcase
         end
         FMR_WRITE: begin
            next_state  = FMR_IDLE;
            next_opDone = 1'b1;
         end
         default: begin
            next_state = FMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state     <= FMR_IDLE;
         op        <= OP_MOVE_TO_ACC;
         acc       <= ACC_RESET;
         zeroFlag  <= FLAG_RESET;
         carryFlag <= FLAG_RESET;
         memRdEn   <= 1'b0;
         memWrEn   <= 1'b0;
         memAddr   <= 8'h00;
         memWrData <= 8'h00;
         opDone    <= 1'b0;
         opBusy    <= 1'b0;
      end else begin
         state     <= next_state;
         op        <= next_op;
         acc       <= next_acc;
         zeroFlag  <= next_zeroFlag;
         carryFlag <= next_carryFlag;
         memRdEn   <= next_memRdEn;
         memWrEn   <= next_memWrEn;
         memAddr   <= next_memAddr;
         memWrData <= next_memWrData;
         opDone    <= next_opDone;
         opBusy    <= (next_state != FMR_IDLE);
      end
   end

   chk_move_acc_load: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_MOVE_TO_ACC) |=>
         (acc == $past(memRdData) && $stable(zeroFlag) && $stable(carryFlag)))
      else $error("move to accumulator wrong");

   chk_move_mem_write: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_IDLE && opStart && opCode == OP_MOVE_TO_MEM) |=>
         (memWrEn && memWrData == $past(acc) && $stable(acc)
          && $stable(zeroFlag) && $stable(carryFlag)))
      else $error("move to memory wrong");

   chk_or_acc_zero: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_OR_TO_ACC) |=>
         (acc == ($past(acc) | $past(memRdData)) && zeroFlag == (acc == 8'h00)
          && $stable(carryFlag)))
      else $error("or to accumulator wrong");

   chk_or_mem_write: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_OR_TO_MEM) |=>
         (memWrEn && memWrData == (acc | $past(memRdData)) && $stable(acc)
          && zeroFlag == (memWrData == 8'h00)) ##1 opDone)
      else $error("or to memory wrong");

   chk_rot_mem_value: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_ROT_MEM) |=>
         (memWrEn && memWrData == {$past(memRdData[6:0]), $past(memRdData[7])}
          && $stable(carryFlag) && $stable(zeroFlag) && $stable(acc)))
      else $error("rotate memory wrong");

   chk_rot_acc_value: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_ROT_ACC) |=>
         (acc == {$past(memRdData[6:0]), $past(memRdData[7])} && !memWrEn
          && $stable(carryFlag) && $stable(zeroFlag)))
      else $error("rotate to accumulator wrong");

   chk_rotc_mem_carry: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_ROTC_MEM) |=>
         (memWrEn && memWrData == {$past(memRdData[6:0]), $past(carryFlag)}
          && carryFlag == $past(memRdData[7]) && $stable(zeroFlag)))
      else $error("rotate memory through carry wrong");

   chk_rotc_acc_carry: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (state == FMR_READ && op == OP_ROTC_ACC) |=>
         (acc == {$past(memRdData[6:0]), $past(carryFlag)}
          && carryFlag == $past(memRdData[7]) && !memWrEn
          && $stable(zeroFlag)))
      else $error("rotate to accumulator through carry wrong");

endmodule

//--- verification/fmr_mem_model.sv
`timescale 1ns/10ps
module fmr_mem_model (
   input  wire logic       ref_clk,
   input  wire logic       memRdEn,
   input  wire logic       memWrEn,
   input  wire logic [7:0] memAddr,
   input  wire logic [7:0] memWrData,
   output logic      [7:0] memRdData
);
   logic [7:0] mem [256];
   logic [7:0] lastRd;
   initial lastRd = 8'h00;
   // Read data stands while memRdEn is high, since the core takes it at the
   // edge that ends the strobe. Outside the read slot the lines show the
   // inverse of what they last showed, so stale data never passes.
   always @(posedge ref_clk) begin
      if (memWrEn) mem[memAddr] <= memWrData;
      lastRd <= memRdData;
   end
   assign memRdData = memRdEn ? mem[memAddr] : ~lastRd;
endmodule

//--- verification/test_far_memory_move_or_rotate_left.sv
`timescale 1ns/10ps
module test_far_memory_move_or_rotate_left;
   import fmr_pkg::*;
   logic       ref_clk, resetn, opStart, opBusy, opDone, memRdEn;
   logic       memWrEn, zeroFlag, carryFlag;
   logic [3:0] opCode;
   logic [7:0] memAddrIn, memRdData, memAddr, memWrData, acc;
   int         numErrors, checked, cycles;
   fmr_core dut (.ref_clk(ref_clk), .resetn(resetn), .opStart(opStart),
      .opCode(opCode), .memAddrIn(memAddrIn), .memRdData(memRdData),
      .opBusy(opBusy), .opDone(opDone), .memRdEn(memRdEn),
      .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
      .acc(acc), .zeroFlag(zeroFlag), .carryFlag(carryFlag));
   fmr_mem_model ram (.ref_clk(ref_clk), .memRdEn(memRdEn),
      .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
      .memRdData(memRdData));
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic run_op(logic [3:0] code, logic [7:0] addr);
      int n;
      @(negedge ref_clk);
      opStart = 1'b1;
      opCode = code;
      memAddrIn = addr;
      @(negedge ref_clk);
      opStart = 1'b0;
      check("opBusy", {7'h0, opBusy}, {7'h0, code <= OP_ROTC_ACC});
      n = 0;
      while (opDone !== 1'b1 && n < 10) begin
         @(negedge ref_clk);
         n++;
      end
      check("opDone", {7'h0, opDone}, 8'h01);
      check("opBusy", {7'h0, opBusy}, 8'h00);
   endtask
   task automatic t_move();
      ram.mem[8'h10] = 8'ha5;
      run_op(OP_MOVE_TO_ACC, 8'h10);
      check("acc", acc, 8'ha5);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h00);
      run_op(OP_MOVE_TO_MEM, 8'h11);
      check("mem", ram.mem[8'h11], 8'ha5);
      check("acc", acc, 8'ha5);
   endtask
   task automatic t_or();
      ram.mem[8'h12] = 8'h5a;
      run_op(OP_OR_TO_ACC, 8'h12);
      check("acc", acc, 8'hff);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h00);
      ram.mem[8'h14] = 8'h10;
      run_op(OP_OR_TO_MEM, 8'h14);
      check("mem", ram.mem[8'h14], 8'hff);
      check("acc", acc, 8'hff);
      ram.mem[8'h13] = 8'h00;
      run_op(OP_MOVE_TO_ACC, 8'h13);
      run_op(OP_OR_TO_MEM, 8'h13);
      check("mem", ram.mem[8'h13], 8'h00);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h02);
   endtask
   task automatic t_rot();
      ram.mem[8'h20] = 8'h81;
      run_op(OP_ROT_MEM, 8'h20);
      check("mem", ram.mem[8'h20], 8'h03);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h02);
      run_op(OP_ROT_ACC, 8'h20);
      check("acc", acc, 8'h06);
      check("mem", ram.mem[8'h20], 8'h03);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h02);
   endtask
   task automatic t_rotc();
      ram.mem[8'h30] = 8'h80;
      run_op(OP_ROTC_MEM, 8'h30);
      check("mem", ram.mem[8'h30], 8'h00);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h03);
      run_op(OP_MOVE_TO_ACC, 8'h30);
      check("acc", acc, 8'h00);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h03);
      ram.mem[8'h32] = 8'h01;
      ram.mem[8'h33] = 8'h00;
      run_op(OP_OR_TO_ACC, 8'h32);
      check("acc", acc, 8'h01);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h01);
      run_op(OP_MOVE_TO_ACC, 8'h33);
      run_op(OP_OR_TO_ACC, 8'h33);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h03);
      run_op(OP_MOVE_TO_MEM, 8'h34);
      check("mem", ram.mem[8'h34], 8'h00);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h03);
      ram.mem[8'h31] = 8'h41;
      run_op(OP_ROTC_ACC, 8'h31);
      check("acc", acc, 8'h83);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h02);
      check("mem", ram.mem[8'h31], 8'h41);
   endtask
   task automatic t_unknown();
      run_op(4'hf, 8'h31);
      check("acc", acc, 8'h83);
      check("flags", {6'h0, zeroFlag, carryFlag}, 8'h02);
      check("mem", ram.mem[8'h31], 8'h41);
   endtask
   task automatic t_reset();
      @(negedge ref_clk);
      resetn = 1'b0;
      @(negedge ref_clk);
      check("acc", acc, ACC_RESET);
      check("flags", {6'h0, zeroFlag, carryFlag},
            {6'h0, FLAG_RESET, FLAG_RESET});
      check("opBusy", {7'h0, opBusy}, 8'h00);
      resetn = 1'b1;
      run_op(OP_MOVE_TO_ACC, 8'h31);
      check("acc", acc, 8'h41);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Every scenario ends well inside this ceiling; a hang lands here.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         numErrors++;
         test_done();
      end
   end
   initial begin
      resetn = 1'b0;
      opStart = 1'b0;
      opCode = 4'h0;
      memAddrIn = 8'h00;
      repeat (2) @(negedge ref_clk);
      check("acc", acc, ACC_RESET);
      resetn = 1'b1;
      t_move();
      t_or();
      t_rot();
      t_rotc();
      t_unknown();
      t_reset();
      test_done();
   end
endmodule
